//--- design/uers_params.svh
`ifndef UERS_PARAMS_SVH
`define UERS_PARAMS_SVH
`define UERS_CLK_HZ 25000000
`define UERS_OFF_CTRL 12'h000
`define UERS_OFF_STAT 12'h004
`define UERS_OFF_SYNAD 12'h008
`define UERS_OFF_CMD 12'h00c
`define UERS_OFF_IRQ_ST 12'h010
`define UERS_OFF_IRQ_CLR 12'h014
`define UERS_OFF_IRQ_EN 12'h018
`define UERS_OFF_CERR 12'h01c
`define UERS_STG_REG 3'h2
`define UERS_ACT_REG 3'h4
`define UERS_CTRL_RST 8'h00
`define UERS_CMD_RST 32'h0000_0000
`define UERS_CFG_RST 16'h0000
`define UERS_IRQ_EN_RST 4'h0
`define UERS_DIG_RUN 4'h1
`define UERS_DIG_STOP 4'h0
`define UERS_NCFG 96
`define UERS_CFG_BASE 7
`define UERS_CFG_STRIDE 3
`define UERS_TYPE_MAX 16'h00ff
`define UERS_RETRIES 2'h2
`define UERS_CODE_NONE 8'h00
`define UERS_CODE_SYN 8'h02
`define UERS_CODE_DM 8'h15
`define UERS_CODE_WDT 8'h11
`define UERS_CODE_LINK 8'h12
`define UERS_CODE_CPUTMO 8'h13
`define UERS_CODE_CPURUN 8'h14
`define UERS_CODE_CTMO 8'h01
`define UERS_STEP_MS 500
`define UERS_TMO_MAX_MS 5000
`define UERS_TMO_NMAX (4'(`UERS_TMO_MAX_MS / `UERS_STEP_MS - 1))
`define UERS_STEP_CYC (32'((`UERS_CLK_HZ / 1000) * `UERS_STEP_MS))
`define UERS_CPU_RETRY_S 120
`define UERS_CPU_RETRY_CYC (32'(64'(`UERS_CPU_RETRY_S) * 64'(`UERS_CLK_HZ)))
`define UERS_FLASH_MS 250
`define UERS_FLASH_CYC (32'((`UERS_CLK_HZ / 1000) * `UERS_FLASH_MS))
`endif

//--- design/uers_pkg.sv
package uers_pkg;
   typedef enum logic [1:0] {
      UERS_STOP = 2'b00,
      UERS_RUN = 2'b01,
      UERS_HALT = 2'b10
   } uers_run_t;
endpackage

//--- design/uers_supervisor.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "uers_params.svh"
// Functional notes
// - A write refused because the CPU is running is retried twice with mode change.
// - When those retries all fail, enter fatal state with lamp steadily on.
// - Component configuration words are taken only on a stop-to-run change.
// - Command bits act at once, without any stop-to-run change.
// - Syntax error is non-fatal and clears only on a stop-to-run change.
// - Memory allocation error is fatal and clears only on power-up reset.
// - Component response timeout is set in 500 ms steps, up to 5.0 s.
// - Timeout setting zero gives 500 ms monitoring.
// - Lamp steady while fatal, flashing while only non-fatal errors stand.
// - Allocation error writes code 15 into the status word.
// - Internal watchdog expiry is fatal, reported in status, cleared by reset.
// - CPU link failure flagged on cpu_link_err is fatal until reset; no link at all (cpu_link_up low) is not.
// - Writes still blocked by a running CPU after both retries are reported as fatal until reset.
// - Control bits 3:0 are the run digit: 1 runs, 0 stops.
// - Syntax error writes code 02 and the offending word offset.
// - A silent CPU is retried for two minutes, then the unit goes fatal.
// - A component error is non-fatal; record code, drop it, move on.
module uers_supervisor #(
   parameter int NCFG = `UERS_NCFG,
   parameter logic [15:0] TYPE_MAX = `UERS_TYPE_MAX,
   parameter logic [31:0] STEP_CYC = `UERS_STEP_CYC,
   parameter logic [31:0] CPU_RETRY_CYC = `UERS_CPU_RETRY_CYC,
   parameter logic [31:0] FLASH_CYC = `UERS_FLASH_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic cpu_link_up,
   input wire logic cpu_link_err,
   input wire logic cpu_req_pend,
   input wire logic cpu_resp,
   input wire logic wr_fail_run,
   input wire logic wr_ok,
   input wire logic wdt_expired,
   input wire logic dm_alloc_err,
   input wire logic comp_req,
   input wire logic comp_resp,
   input wire logic comp_nak,
   input wire logic [7:0] comp_nak_code,
   input wire logic [4:0] comp_unit,
   output logic run_active,
   output logic retry_req,
   output logic comp_next,
   output logic [31:0] comp_cmd,
   output logic err_lamp,
   output logic irq
);
   logic ap, dp_wr_ff, hready_ff, run_ff, retry_req_ff, comp_next_ff, lamp_ff, irq_ff;
   logic [11:0] dp_adr_ff;
   logic [6:0] widx, ridx;
   logic wr_ctrl, wr_cmd, wr_clr, wr_en, wr_stg;
   logic [7:0] ctrl_ff, code_ff, synad_ff, fat_code, syn_off;
   logic [31:0] cmd_ff, hrdata_ff, cpu_cnt_ff, fl_cnt_ff;
   logic [15:0] stg_ff [NCFG];
   logic [15:0] act_ff [NCFG];
   logic [15:0] cerr_ff;
   logic [3:0] digit, irq_st_ff, irq_en_ff, clr, ev, nxt_irq_st;
   logic [1:0] rty_ff;
   logic syn_bad, s2r, fatal_ff, syn_ff, comp_err_ff, nonfatal, blink_ff;
   logic cpu_tmo, rty_x, fat_ev, cerr_ev;
   uers_pkg::uers_run_t st_ff, nxt_st;
   uers_tmo_if tif();

   // Zero-wait slave; read data is captured in the address phase.
   assign ap = hsel && htrans[1] && hready;
   assign widx = dp_adr_ff[8:2];
   assign ridx = haddr[8:2];
   assign wr_ctrl = dp_wr_ff && (dp_adr_ff == `UERS_OFF_CTRL);
   assign wr_cmd = dp_wr_ff && (dp_adr_ff == `UERS_OFF_CMD);
   assign wr_clr = dp_wr_ff && (dp_adr_ff == `UERS_OFF_IRQ_CLR);
   assign wr_en = dp_wr_ff && (dp_adr_ff == `UERS_OFF_IRQ_EN);
   assign wr_stg = dp_wr_ff && (dp_adr_ff[11:9] == `UERS_STG_REG) && (widx < 7'(NCFG));

   always_ff @(posedge clk) begin
      if (rst) begin
         dp_wr_ff <= 1'b0;
         dp_adr_ff <= 12'h000;
         hready_ff <= 1'b1;
      end else begin
         dp_wr_ff <= ap && hwrite;
         hready_ff <= 1'b1;
         if (ap) begin
            dp_adr_ff <= haddr[11:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= `UERS_CTRL_RST;
         cmd_ff <= `UERS_CMD_RST;
         irq_en_ff <= `UERS_IRQ_EN_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= hwdata[7:0];
         end
         // Command bits go straight to the scan engine on every cycle.
         if (wr_cmd) begin
            cmd_ff <= hwdata;
         end
         if (wr_en) begin
            irq_en_ff <= hwdata[3:0];
         end
      end
   end

   for (genvar i = 0; i < NCFG; i++) begin : g_cfg
      always_ff @(posedge clk) begin
         if (rst) begin
            stg_ff[i] <= `UERS_CFG_RST;
            act_ff[i] <= `UERS_CFG_RST;
         end else begin
            if (wr_stg && widx == 7'(i)) begin
               stg_ff[i] <= hwdata[15:0];
            end
            if (s2r) begin
               act_ff[i] <= stg_ff[i];
            end
         end
      end
   end

   // The lowest bad offset is reported, so the scan runs downwards.
   always_comb begin
      syn_bad = 1'b0;
      syn_off = 8'h00;
      for (int k = NCFG - `UERS_CFG_STRIDE; k >= 0; k -= `UERS_CFG_STRIDE) begin
         if (stg_ff[k] > TYPE_MAX) begin
            syn_bad = 1'b1;
            syn_off = 8'(k + `UERS_CFG_BASE);
         end
      end
      if (ctrl_ff[7:4] > `UERS_TMO_NMAX) begin
         syn_bad = 1'b1;
         syn_off = 8'h00;
      end
   end

   assign digit = ctrl_ff[3:0];
   assign cpu_tmo = cpu_link_up && cpu_req_pend && !cpu_resp
                    && (cpu_cnt_ff == CPU_RETRY_CYC - 32'h1);
   assign rty_x = wr_fail_run && (rty_ff == `UERS_RETRIES);
   assign fat_ev = dm_alloc_err || wdt_expired || cpu_link_err || cpu_tmo || rty_x;
   assign s2r = (st_ff == uers_pkg::UERS_STOP) && (digit == `UERS_DIG_RUN)
                && !fat_ev && !fatal_ff;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         uers_pkg::UERS_STOP: if (digit == `UERS_DIG_RUN) nxt_st = uers_pkg::UERS_RUN;
         uers_pkg::UERS_RUN: if (digit != `UERS_DIG_RUN) nxt_st = uers_pkg::UERS_STOP;
         default: nxt_st = uers_pkg::UERS_HALT;
      endcase
      if (fat_ev || fatal_ff) begin
         nxt_st = uers_pkg::UERS_HALT;
      end
   end

   always_comb begin
      if (dm_alloc_err) fat_code = `UERS_CODE_DM;
      else if (wdt_expired) fat_code = `UERS_CODE_WDT;
      else if (cpu_link_err) fat_code = `UERS_CODE_LINK;
      else if (cpu_tmo) fat_code = `UERS_CODE_CPUTMO;
      else fat_code = `UERS_CODE_CPURUN;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= uers_pkg::UERS_STOP;
         run_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         run_ff <= (nxt_st == uers_pkg::UERS_RUN);
      end
   end

   // Only reset leaves the fatal state; fixing the cause is not enough.
   always_ff @(posedge clk) begin
      if (rst) begin
         fatal_ff <= 1'b0;
         syn_ff <= 1'b0;
         code_ff <= `UERS_CODE_NONE;
         synad_ff <= 8'h00;
      end else if (!fatal_ff && fat_ev) begin
         fatal_ff <= 1'b1;
         code_ff <= fat_code;
      end else if (s2r) begin
         syn_ff <= syn_bad;
         code_ff <= syn_bad ? `UERS_CODE_SYN : `UERS_CODE_NONE;
         if (syn_bad) begin
            synad_ff <= syn_off;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rty_ff <= 2'h0;
         retry_req_ff <= 1'b0;
      end else begin
         retry_req_ff <= 1'b0;
         if (wr_ok) begin
            rty_ff <= 2'h0;
         end else if (wr_fail_run && !fatal_ff && !rty_x) begin
            rty_ff <= rty_ff + 2'h1;
            retry_req_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !cpu_link_up || !cpu_req_pend || cpu_resp) begin
         cpu_cnt_ff <= 32'h0;
      end else if (!cpu_tmo) begin
         cpu_cnt_ff <= cpu_cnt_ff + 32'h1;
      end
   end

   assign tif.start = comp_req && (st_ff == uers_pkg::UERS_RUN);
   assign tif.stop = comp_resp || comp_nak;
   assign tif.tsel = ctrl_ff[7:4];

   uers_tmo_timer #(
      .STEP_CYC(STEP_CYC)
   ) u_tmo (
      .clk(clk),
      .rst(rst),
      .tif(tif)
   );

   assign cerr_ev = tif.expire || comp_nak;

   always_ff @(posedge clk) begin
      if (rst) begin
         comp_err_ff <= 1'b0;
         comp_next_ff <= 1'b0;
         cerr_ff <= 16'h0000;
      end else begin
         comp_next_ff <= cerr_ev;
         if (cerr_ev) begin
            comp_err_ff <= 1'b1;
            cerr_ff <= {tif.expire ? `UERS_CODE_CTMO : comp_nak_code, 3'h0, comp_unit};
         end else if (comp_resp) begin
            comp_err_ff <= 1'b0;
         end
      end
   end

   assign nonfatal = syn_ff || comp_err_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         fl_cnt_ff <= 32'h0;
         blink_ff <= 1'b0;
      end else if (fl_cnt_ff == FLASH_CYC - 32'h1) begin
         fl_cnt_ff <= 32'h0;
         blink_ff <= !blink_ff;
      end else begin
         fl_cnt_ff <= fl_cnt_ff + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lamp_ff <= 1'b0;
      end else begin
         lamp_ff <= fatal_ff || (nonfatal && blink_ff);
      end
   end

   // A set in the same cycle as its clear wins.
   assign clr = wr_clr ? hwdata[3:0] : 4'h0;
   assign ev = {s2r, cerr_ev, s2r && syn_bad, !fatal_ff && fat_ev};
   assign nxt_irq_st = (irq_st_ff & ~clr) | ev;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_st_ff <= 4'h0;
         irq_ff <= 1'b0;
      end else begin
         irq_st_ff <= nxt_irq_st;
         irq_ff <= |(nxt_irq_st & irq_en_ff);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata_ff <= 32'h0;
      end else if (ap && !hwrite) begin
         if (haddr[11:0] == `UERS_OFF_CTRL) hrdata_ff <= {24'h0, ctrl_ff};
         else if (haddr[11:0] == `UERS_OFF_STAT)
            hrdata_ff <= {21'h0, run_ff, nonfatal, fatal_ff, code_ff};
         else if (haddr[11:0] == `UERS_OFF_SYNAD) hrdata_ff <= {24'h0, synad_ff};
         else if (haddr[11:0] == `UERS_OFF_CMD) hrdata_ff <= cmd_ff;
         else if (haddr[11:0] == `UERS_OFF_IRQ_ST) hrdata_ff <= {28'h0, irq_st_ff};
         else if (haddr[11:0] == `UERS_OFF_IRQ_EN) hrdata_ff <= {28'h0, irq_en_ff};
         else if (haddr[11:0] == `UERS_OFF_CERR) hrdata_ff <= {16'h0, cerr_ff};
         else if (haddr[11:9] == `UERS_STG_REG && ridx < 7'(NCFG))
            hrdata_ff <= {16'h0, stg_ff[ridx]};
         else if (haddr[11:9] == `UERS_ACT_REG && ridx < 7'(NCFG))
            hrdata_ff <= {16'h0, act_ff[ridx]};
         else hrdata_ff <= 32'h0;
      end
   end

   assign hreadyout = hready_ff;
   assign hrdata = hrdata_ff;
   assign hresp = 1'b0;
   assign run_active = run_ff;
   assign retry_req = retry_req_ff;
   assign comp_next = comp_next_ff;
   assign comp_cmd = cmd_ff;
   assign err_lamp = lamp_ff;
   assign irq = irq_ff;

   retry_pulse_a: assert property (@(posedge clk) disable iff (rst)
      wr_fail_run && !wr_ok && !fatal_ff && rty_ff < 2'h2 |=> retry_req_ff)
      else $error("refused write not retried");
   retry_fatal_a: assert property (@(posedge clk) disable iff (rst)
      wr_fail_run && rty_ff == 2'h2 |=> fatal_ff ##1 err_lamp)
      else $error("third refused write did not go fatal");
   lamp_steady_a: assert property (@(posedge clk) disable iff (rst)
      fatal_ff |=> err_lamp)
      else $error("lamp not steady in fatal state");
   cfg_hold_a: assert property (@(posedge clk) disable iff (rst)
      !s2r |=> $stable(act_ff[0]) && $stable(act_ff[NCFG-1]))
      else $error("active configuration changed outside stop-to-run");
   cmd_live_a: assert property (@(posedge clk) disable iff (rst)
      wr_cmd |=> comp_cmd == $past(hwdata))
      else $error("command bits not applied at once");
   syn_code_a: assert property (@(posedge clk) disable iff (rst)
      s2r && syn_bad |=> syn_ff && code_ff == 8'h02 && synad_ff == $past(syn_off))
      else $error("syntax error not reported");
   syn_keep_a: assert property (@(posedge clk) disable iff (rst)
      syn_ff && !s2r |=> syn_ff)
      else $error("syntax error cleared without stop-to-run");
   dm_code_a: assert property (@(posedge clk) disable iff (rst)
      dm_alloc_err && !fatal_ff |=> fatal_ff && code_ff == 8'h15)
      else $error("allocation error code missing");
   fatal_keep_a: assert property (@(posedge clk) disable iff (rst)
      fatal_ff |=> fatal_ff && $stable(code_ff) && !run_active)
      else $error("fatal state left without reset");
   cpu_silent_a: assert property (@(posedge clk) disable iff (rst)
      cpu_tmo |=> fatal_ff && code_ff != 8'h00)
      else $error("silent CPU did not go fatal");
   comp_drop_a: assert property (@(posedge clk) disable iff (rst)
      tif.expire |=> comp_next && comp_err_ff && !fatal_ff)
      else $error("component error not handled as non-fatal");
endmodule // uers_supervisor
`default_nettype wire

//--- design/uers_tmo_if.sv
`timescale 1ns/1ns
`default_nettype none
interface uers_tmo_if;
   logic start;
   logic stop;
   logic [3:0] tsel;
   logic expire;
   modport ctl (output start, output stop, output tsel, input expire);
   modport tmr (input start, input stop, input tsel, output expire);
endinterface
`default_nettype wire

//--- design/uers_tmo_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "uers_params.svh"
module uers_tmo_timer #(
   parameter logic [31:0] STEP_CYC = `UERS_STEP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   uers_tmo_if.tmr tif
);
   logic armed_ff;
   logic [31:0] pre_ff;
   logic [3:0] steps_ff;
   logic [3:0] lim;
   logic tick;
   logic exp_ff;

   // Out-of-range settings fall back to one step; they are flagged as syntax errors.
   assign lim = (tif.tsel > `UERS_TMO_NMAX) ? 4'h0 : tif.tsel;
   assign tick = armed_ff && (pre_ff == STEP_CYC - 32'h1);
   assign tif.expire = exp_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         armed_ff <= 1'b0;
         pre_ff <= 32'h0;
         steps_ff <= 4'h0;
         exp_ff <= 1'b0;
      end else begin
         exp_ff <= 1'b0;
         if (tif.start) begin
            armed_ff <= 1'b1;
            pre_ff <= 32'h0;
            steps_ff <= 4'h0;
         end else if (tif.stop) begin
            armed_ff <= 1'b0;
         end else if (tick) begin
            pre_ff <= 32'h0;
            if (steps_ff == lim) begin
               armed_ff <= 1'b0;
               exp_ff <= 1'b1;
            end else begin
               steps_ff <= steps_ff + 4'h1;
            end
         end else if (armed_ff) begin
            pre_ff <= pre_ff + 32'h1;
         end
      end
   end

   expire_steps_a: assert property (@(posedge clk) disable iff (rst)
      exp_ff |-> $past(armed_ff) && $past(steps_ff) == $past(lim))
      else $error("timeout fired before the selected step count");
endmodule // uers_tmo_timer
`default_nettype wire

//--- tb/uers_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module uers_cpu_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_go,
   input wire logic run_mode,
   input wire logic silent,
   input wire logic break_link,
   input wire logic retry_req,
   output logic cpu_link_up,
   output logic cpu_link_err,
   output logic cpu_req_pend,
   output logic cpu_resp,
   output logic wr_fail_run,
   output logic wr_ok
);
   // A CPU left in run mode refuses every write, retries included, so the unit must give up.
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_link_up <= 1'b0;
         cpu_link_err <= 1'b0;
         cpu_req_pend <= 1'b0;
         cpu_resp <= 1'b0;
         wr_fail_run <= 1'b0;
         wr_ok <= 1'b0;
      end else begin
         cpu_link_up <= !break_link;
         cpu_link_err <= break_link;
         cpu_req_pend <= silent;
         cpu_resp <= cpu_req_pend && !silent;
         wr_fail_run <= (wr_go || retry_req) && run_mode;
         wr_ok <= (wr_go || retry_req) && !run_mode;
      end
   end
endmodule // uers_cpu_model
`default_nettype wire

//--- tb/unit_error_run_supervisor_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "uers_params.svh"
module unit_error_run_supervisor_tb;
   localparam int STEP = 20;
   localparam logic [31:0] A_CTRL = 32'(`UERS_OFF_CTRL);
   localparam logic [31:0] A_STAT = 32'(`UERS_OFF_STAT);
   localparam logic [31:0] A_CMD = 32'(`UERS_OFF_CMD);
   localparam logic [31:0] A_CERR = 32'(`UERS_OFF_CERR);
   logic clk, rst, hsel, hwrite, hreadyout, hresp, err_lamp, irq, run_active;
   logic retry_req, comp_next, link_up, link_err, req_pend, resp, wfail, wok;
   logic [31:0] haddr, hwdata, hrdata, comp_cmd;
   logic [1:0] htrans;
   logic [7:0] nak_code;
   logic [4:0] unit;
   logic [8:0] ev;
   int fails, total_checks;
   uers_supervisor #(.STEP_CYC(32'h14), .CPU_RETRY_CYC(32'h32), .FLASH_CYC(32'h8)) u_dut (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .cpu_link_up(link_up), .cpu_link_err(link_err),
      .cpu_req_pend(req_pend), .cpu_resp(resp), .wr_fail_run(wfail), .wr_ok(wok),
      .wdt_expired(ev[3]), .dm_alloc_err(ev[4]), .comp_req(ev[0]), .comp_resp(ev[1]),
      .comp_nak(ev[2]), .comp_nak_code(nak_code), .comp_unit(unit), .run_active(run_active),
      .retry_req(retry_req), .comp_next(comp_next), .comp_cmd(comp_cmd), .err_lamp(err_lamp),
      .irq(irq));
   uers_cpu_model u_cpu (
      .clk(clk), .rst(rst), .wr_go(ev[5]), .run_mode(ev[7]), .silent(ev[8]),
      .break_link(ev[6]), .retry_req(retry_req), .cpu_link_up(link_up),
      .cpu_link_err(link_err), .cpu_req_pend(req_pend), .cpu_resp(resp), .wr_fail_run(wfail),
      .wr_ok(wok));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q & m);
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev[b] <= 1'b0;
   endtask
   // Counts lamp toggles and lit cycles over a span of four flash periods.
   task automatic lamp(output int t, output int h);
      logic b;
      b = err_lamp;
      t = 0;
      h = 0;
      repeat (32) begin
         @(posedge clk);
         if (err_lamp !== b) t++;
         if (err_lamp === 1'b1) h++;
         b = err_lamp;
      end
   endtask
   task automatic reset_dut(input int n);
      @(posedge clk);
      rst <= 1'b1;
      ev <= 9'h0;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic tend(input string nm);
      $display("test %s done", nm);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("watchdog expired");
      finish_test();
   end
   initial begin
      logic [31:0] addrs [9] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h18, 32'h1c, 32'h400,
                                 32'h0f0};
      logic [7:0] codes [5] = '{8'h15, 8'h11, 8'h12, 8'h13, 8'h14};
      int k, r, t, h, lo;
      logic [31:0] fx;
      {hsel, hwrite, htrans, haddr, hwdata, ev, nak_code, unit} = '0;
      rst = 1'b1;
      reset_dut(20);
      foreach (addrs[i]) rdc("reset value", addrs[i], 32'hffff_ffff, 32'h0);
      chk("hresp", 32'h0, {31'h0, hresp});
      tend("reset");
      // The mode command is written once, never repeated on every scan.
      wr(A_CMD, 32'ha5a5_0f0f);
      @(posedge clk);
      chk("comp_cmd", 32'ha5a5_0f0f, comp_cmd);
      tend("command");
      wr(32'h404, 32'h0012);
      wr(A_CTRL, 32'h1);
      // The state follows the digit one edge after the write lands.
      repeat (2) @(posedge clk);
      chk("run_active", 32'h1, {31'h0, run_active});
      rdc("stat run", A_STAT, 32'h400, 32'h400);
      rdc("irq start", 32'h10, 32'h8, 32'h8);
      rdc("active cfg", 32'h804, 32'hffff, 32'h12);
      wr(32'h404, 32'h0034);
      rdc("cfg held", 32'h804, 32'hffff, 32'h12);
      wr(A_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      chk("stopped", 32'h0, {31'h0, run_active});
      wr(A_CTRL, 32'h1);
      rdc("cfg taken", 32'h804, 32'hffff, 32'h34);
      tend("config");
      wr(32'h18, 32'h2);
      wr(32'h400, 32'h0100);
      wr(A_CTRL, 32'h0);
      wr(A_CTRL, 32'h1);
      rdc("syntax stat", A_STAT, 32'h3ff, 32'h202);
      rdc("syntax addr", 32'h8, 32'hff, 32'h7);
      chk("irq set", 32'h1, {31'h0, irq});
      lamp(t, h);
      chk("lamp flash", 32'h1, {31'h0, t >= 2});
      wr(32'h14, 32'h2);
      @(posedge clk);
      chk("irq clear", 32'h0, {31'h0, irq});
      wr(32'h400, 32'h0);
      rdc("syntax held", A_STAT, 32'h200, 32'h200);
      wr(A_CTRL, 32'h0);
      wr(A_CTRL, 32'h1);
      rdc("syntax gone", A_STAT, 32'h200, 32'h0);
      tend("syntax");
      for (int n = 0; n < 10; n += 9) begin
         wr(A_CTRL, {24'h0, 4'(n), 4'h1});
         unit <= 5'(n + 3);
         pulse(0);
         k = 0;
         while (comp_next !== 1'b1 && k < 400) begin
            @(posedge clk);
            k++;
         end
         lo = (n + 1) * STEP;
         chk("tmo span", 32'h1, {31'h0, k >= lo && k <= lo + n + 3});
         rdc("tmo cerr", A_CERR, 32'hff1f, 32'h0100 | 32'(n + 3));
         rdc("tmo nonfatal", A_STAT, 32'h300, 32'h200);
         pulse(1);
         rdc("tmo cleared", A_STAT, 32'h200, 32'h0);
      end
      nak_code <= 8'h3c;
      pulse(2);
      @(posedge clk);
      chk("nak next", 32'h1, {31'h0, comp_next});
      rdc("nak cerr", A_CERR, 32'hff1f, 32'h3c0c);
      tend("component");
      // Each fatal cause is raised on a fresh run, since only reset clears a fatal state.
      for (int f = 0; f < 5; f++) begin
         reset_dut(3);
         wr(A_CTRL, 32'h1);
         case (f)
            0: pulse(4);
            1: pulse(3);
            2: pulse(6);
            3: ev[8] <= 1'b1;
            default: begin
               ev[7] <= 1'b1;
               pulse(5);
            end
         endcase
         k = 0;
         r = 0;
         while (err_lamp !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
            if (retry_req === 1'b1) r++;
         end
         if (f == 3) chk("silent span", 32'h1, {31'h0, k >= 50});
         if (f == 4) chk("retries", 32'h2, 32'(r));
         fx = 32'h100 | 32'(codes[f]);
         rdc("fatal stat", A_STAT, 32'h7ff, fx);
         chk("halted", 32'h0, {31'h0, run_active});
         pulse(3);
         wr(A_CTRL, 32'h0);
         wr(A_CTRL, 32'h1);
         rdc("fatal kept", A_STAT, 32'h1ff, 32'h100 | 32'(codes[f]));
         lamp(t, h);
         chk("lamp steady", 32'd32, 32'(h));
      end
      tend("fatal");
      finish_test();
   end
endmodule // unit_error_run_supervisor_tb
`default_nettype wire
